/* File: logic/cdb_bank.sv */
// Paged CPU diagnose and configuration register bank with Wishbone access
//
// Decided for this implementation: the Wishbone register port and the register addresses.
`timescale 1ns/10ps
module cdb_bank #(
  parameter int DIAG_REGS = 35,
  parameter int LAB_DEPTH = 4
) (
  input  wire logic                    CLK_I,
  input  wire logic                    RESET_I,
  // Wishbone classic slave
  input  wire logic                    CYC_I,
  input  wire logic                    STB_I,
  input  wire logic                    WE_I,
  input  wire logic [7:0]              ADR_I,
  input  wire logic [3:0]              SEL_I,
  input  wire logic [31:0]             DAT_I,
  output logic [31:0]                  DAT_O,
  output logic                         ACK_O,
  // Core controls
  output cdb_pkg::cdb_core_ctrl_s      CORE_CTRL_O,
  // Instruction buses from decode
  input  wire logic                    INT_INSN_VALID_I,
  input  wire logic                    INT_MINOR_UNDEF_I,
  input  wire logic                    LDST_INSN_VALID_I,
  input  wire logic                    LDST_MINOR_UNDEF_I,
  input  wire logic                    LDST_INSN_IS_FP_I,
  output logic                         ILLEGAL_TRAP_O,
  // Load miss stall steering
  input  wire logic                    LOAD_MISS_I,
  output logic                         LOAD_MISS_DEFER_O,
  // Cache diagnose engines
  output logic                         ICACHE_DIAG_START_O,
  output logic                         DCACHE_DIAG_START_O,
  output logic                         CACHE_DIAG_BIST_O,
  input  wire logic                    ICACHE_DIAG_DONE_I,
  input  wire logic                    DCACHE_DIAG_DONE_I,
  // Lookaside buffer prefetch and lookup
  input  wire logic                    LAB_PF_VALID_I,
  input  cdb_pkg::cdb_lab_entry_s      LAB_PF_ENTRY_I,
  input  wire logic [1:0]              LAB_LOOKUP_IDX_I,
  output cdb_pkg::cdb_lab_entry_s      LAB_LOOKUP_ENTRY_O
);
  import cdb_pkg::*;

  // Merge write data into a word under byte enables
  function automatic logic [31:0] merge_sel(input logic [31:0] old_v,
                                            input logic [31:0] new_v,
                                            input logic [3:0]  sel);
    logic [31:0] r;
    r = old_v;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        r[b*8 +: 8] = new_v[b*8 +: 8];
      end
    end
    return r;
  endfunction

  // Flat register index from page and 5-bit number
  // Page one starts right after the 32 that a 5-bit number reaches
  function automatic int flat_index(input logic page, input logic [NUM_W-1:0] num);
    return page ? (PAGE_SIZE + int'(num)) : int'(num);
  endfunction

  // Write strobe aimed at one register offset
  function automatic logic wr_hit(input logic strobe, input logic [7:0] adr, input logic [7:0] ofs);
    return strobe && (adr == ofs);
  endfunction

  // Bus handshake
  logic               req;            // Live request not yet answered
  logic               wr_strobe;      // Write takes effect this edge
  logic               ack_reg;        // Registered acknowledge
  logic [31:0]        rdata_next;     // Read mux
  logic [31:0]        rdata_reg;      // Read data held for the answer

  // Diagnose registers
  logic [31:0]        diag_reg [DIAG_REGS];   // The whole file
  logic               page_reg;               // 0 = first page
  logic [NUM_W-1:0]   number_reg;             // Register number for moves
  int                 sel_idx;                // Flat target of a move
  logic               sel_ok;                 // Target exists

  // Cache diagnose tracking
  logic               ic_busy_reg;            // Icache op running
  logic               dc_busy_reg;            // Dcache op running
  logic               ic_start_reg;           // One-cycle start
  logic               dc_start_reg;           // One-cycle start
  logic               bist_reg;               // Mode of last start

  // Lookaside buffer access
  logic               lab_wr;                 // Diagnose write command
  logic               lab_rd;                 // Diagnose read command
  logic [LAB_IDX_W-1:0] lab_idx;              // Entry addressed by command
  cdb_lab_entry_s     lab_diag_entry;         // Staged translation
  cdb_lab_entry_s     lab_rd_entry;           // Entry at read port
  logic [LAB_IDX_W-1:0] lab_rd_idx;           // Read port index
  cdb_lab_entry_s     lab_look_reg;           // Registered lookup result

  // Core side
  logic               trap_reg;               // Illegal instruction trap
  logic               defer_reg;              // Load miss deferred to use
  logic               int_chk_hit;            // Integer bus offender this cycle
  logic               ldst_chk_hit;           // Load/store bus offender this cycle
  cdb_core_ctrl_s     ctrl;                   // Controls from diag file

  // Request is answered one cycle after it shows, ack lasts one cycle
  assign req       = CYC_I && STB_I && !ack_reg;
  assign wr_strobe = req && WE_I;

  // Page one holds only three real registers, the rest are holes
  // page and number map onto 35 registers
  assign sel_idx = flat_index(page_reg, number_reg);
  assign sel_ok  = sel_idx < DIAG_REGS;

  // Acknowledge generation; every address is answered, unmapped reads zero
  // Registered answer costs a cycle but keeps ACK_O off the decode path
  always_ff @(posedge CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      ack_reg <= 1'b0;
    end else begin
      ack_reg <= req;
    end
  end

  // Read mux, decoded from the byte address
  always_comb begin
    rdata_next = 32'h0000_0000;
    unique case (ADR_I)
      OFS_PAGE: begin
        rdata_next = {31'h0000_0000, page_reg};
      end
      OFS_NUMBER: begin
        rdata_next = {27'h000_0000, number_reg};
      end
      // move-from reads through the current page
      OFS_DATA: begin
        rdata_next = sel_ok ? diag_reg[sel_idx] : 32'h0000_0000;
      end
      OFS_STATUS: begin
        rdata_next = {30'h0000_0000, dc_busy_reg, ic_busy_reg};
      end
      // Command words and holes read zero
      default: begin
        rdata_next = 32'h0000_0000;
      end
    endcase
  end

  // Read data capture
  // Held after the answer, so DAT_O keeps the last read
  always_ff @(posedge CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      rdata_reg <= 32'h0000_0000;
    end else if (req && !WE_I) begin
      rdata_reg <= rdata_next;
    end
  end

  // Page selection register
  // Commands carry no data, any write to the offset acts
  always_ff @(posedge CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      page_reg <= 1'b0;
    end else if (wr_hit(wr_strobe, ADR_I, OFS_PAGE0_CMD)) begin
      page_reg <= 1'b0;
    end else if (wr_hit(wr_strobe, ADR_I, OFS_PAGE1_CMD)) begin
      page_reg <= 1'b1;
    end
  end

  // Register number used by moves
  // Only byte lane 0 carries the number
  always_ff @(posedge CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      number_reg <= '0;
    end else if (wr_strobe && ADR_I == OFS_NUMBER && SEL_I[0]) begin
      number_reg <= DAT_I[NUM_W-1:0];
    end
  end

  // Lookaside command decode
  assign lab_wr  = wr_hit(wr_strobe, ADR_I, OFS_LAB_CMD) && DAT_I[LAB_CMD_WR_BIT];
  assign lab_rd  = wr_hit(wr_strobe, ADR_I, OFS_LAB_CMD) && !DAT_I[LAB_CMD_WR_BIT];
  assign lab_idx = DAT_I[LAB_IDX_W-1:0];
  assign lab_diag_entry.vpn = diag_reg[LAB_VPN_IDX][TRANS_W-1:0];
  assign lab_diag_entry.rpn = diag_reg[LAB_RPN_IDX][TRANS_W-1:0];

  // Read port serves the diagnose read, otherwise the core lookup
  assign lab_rd_idx = lab_rd ? lab_idx : LAB_LOOKUP_IDX_I;

  // Diagnose register file; a move-to lands here, so does a lookaside read
  // The two never meet: they arrive through different offsets
  always_ff @(posedge CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      for (int i = 0; i < DIAG_REGS; i++) begin
        diag_reg[i] <= (i == CFG_IDX) ? CFG_RESET : OTHER_RESET;
      end
    end else if (wr_strobe && ADR_I == OFS_DATA) begin
      // writes beyond the 35th register are dropped
      if (sel_ok) begin
        diag_reg[sel_idx] <= merge_sel(diag_reg[sel_idx], DAT_I, SEL_I);
      end
    end else if (lab_rd) begin
      // entry read into the staging registers
      diag_reg[LAB_VPN_IDX] <= {{(32-TRANS_W){1'b0}}, lab_rd_entry.vpn};
      diag_reg[LAB_RPN_IDX] <= {{(32-TRANS_W){1'b0}}, lab_rd_entry.rpn};
    end
  end

  // lookaside storage, written from the staging registers
  cdb_lab #(
    .DEPTH (LAB_DEPTH),
    .IDX_W (LAB_IDX_W)
  ) u_lab (
    .clk_i        (CLK_I),
    .reset_i      (RESET_I),
    .diag_wr_i    (lab_wr),
    .diag_idx_i   (lab_idx),
    .diag_entry_i (lab_diag_entry),
    .pf_enable_i  (ctrl.lookaside_prefetch_enable),
    .pf_valid_i   (LAB_PF_VALID_I),
    .pf_entry_i   (LAB_PF_ENTRY_I),
    .rd_idx_i     (lab_rd_idx),
    .rd_entry_o   (lab_rd_entry)
  );

  // Lookup result registered so the output comes from a flop
  // Held during a diagnose read, which borrows the read port
  always_ff @(posedge CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      lab_look_reg <= '0;
    end else if (!lab_rd) begin
      lab_look_reg <= lab_rd_entry;
    end
  end

  // Controls taken from the diagnose file
  assign ctrl.dcache_safe_mode          = diag_reg[CFG_IDX][CFG_SAFE_BIT];
  assign ctrl.stall_on_use_enable       = diag_reg[CFG_IDX][CFG_SOU_BIT];
  assign ctrl.store_hint_enable         = diag_reg[CFG_IDX][CFG_SHINT_BIT];
  // software keeps this set outside test
  assign ctrl.icache_enable             = diag_reg[CFG_IDX][CFG_ICACHE_BIT];
  assign ctrl.dcache_test_mode          = diag_reg[TEST_IDX][TEST_BIT];
  assign ctrl.lookaside_prefetch_enable = diag_reg[PREF_IDX][PREF_BIT];

  // Cache diagnose start pulses, one per command
  // One cycle long, since the answer drops the request next edge
  always_ff @(posedge CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      ic_start_reg <= 1'b0;
      dc_start_reg <= 1'b0;
    end else begin
      ic_start_reg <= wr_hit(wr_strobe, ADR_I, OFS_IC_DIAG);
      dc_start_reg <= wr_hit(wr_strobe, ADR_I, OFS_DC_DIAG);
    end
  end

  // Self-test or diagnose choice for the started op
  always_ff @(posedge CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      bist_reg <= 1'b0;
    end else if (wr_hit(wr_strobe, ADR_I, OFS_IC_DIAG) || wr_hit(wr_strobe, ADR_I, OFS_DC_DIAG)) begin
      bist_reg <= DAT_I[DIAG_BIST_BIT];
    end
  end

  // Busy flags; a start in the same cycle as done keeps the flag set
  always_ff @(posedge CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      ic_busy_reg <= 1'b0;
      dc_busy_reg <= 1'b0;
    end else begin
      if (ic_start_reg) begin
        ic_busy_reg <= 1'b1;
      end else if (ICACHE_DIAG_DONE_I) begin
        ic_busy_reg <= 1'b0;
      end
      if (dc_start_reg) begin
        dc_busy_reg <= 1'b1;
      end else if (DCACHE_DIAG_DONE_I) begin
        dc_busy_reg <= 1'b0;
      end
    end
  end

  // Offenders per bus; floating point on the load/store bus is not watched at all
  // each bus has its own enable
  assign int_chk_hit  = diag_reg[CFG_IDX][CFG_INTCHK_BIT] && INT_INSN_VALID_I && INT_MINOR_UNDEF_I;
  // floating point on the load/store bus is exempt
  assign ldst_chk_hit = diag_reg[CFG_IDX][CFG_LDCHK_BIT] && LDST_INSN_VALID_I && LDST_MINOR_UNDEF_I &&
                        !LDST_INSN_IS_FP_I;

  // Undefined minor opcode trap, one per cycle with an offender on either bus
  always_ff @(posedge CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      trap_reg <= 1'b0;
    end else begin
      trap_reg <= int_chk_hit || ldst_chk_hit;
    end
  end

  // Stall-on-use steering
  // Other stall causes never pass through this flop
  always_ff @(posedge CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      defer_reg <= 1'b0;
    end else begin
      // only a load miss is deferred, other stalls untouched
      defer_reg <= ctrl.stall_on_use_enable && LOAD_MISS_I;
    end
  end

  // Outputs, each from a flop
  // Control levels come straight from the register flops
  assign ACK_O               = ack_reg;
  assign DAT_O               = rdata_reg;
  // safe mode forces sync after each instruction
  // test mode bit drives dcache into test
  assign CORE_CTRL_O         = ctrl;
  assign ILLEGAL_TRAP_O      = trap_reg;
  assign LOAD_MISS_DEFER_O   = defer_reg;
  assign ICACHE_DIAG_START_O = ic_start_reg;
  assign DCACHE_DIAG_START_O = dc_start_reg;
  assign CACHE_DIAG_BIST_O   = bist_reg;
  assign LAB_LOOKUP_ENTRY_O  = lab_look_reg;
endmodule

/* File: logic/cdb_lab.sv */
// Four-entry instruction lookaside buffer storage
`timescale 1ns/10ps
module cdb_lab #(
  parameter int DEPTH = 4,
  parameter int IDX_W = 2
) (
  input  wire logic                    clk_i,
  input  wire logic                    reset_i,
  input  wire logic                    diag_wr_i,
  input  wire logic [IDX_W-1:0]        diag_idx_i,
  input  cdb_pkg::cdb_lab_entry_s      diag_entry_i,
  input  wire logic                    pf_enable_i,
  input  wire logic                    pf_valid_i,
  input  cdb_pkg::cdb_lab_entry_s      pf_entry_i,
  input  wire logic [IDX_W-1:0]        rd_idx_i,
  output cdb_pkg::cdb_lab_entry_s      rd_entry_o
);
  import cdb_pkg::*;

  cdb_lab_entry_s   entry_reg [DEPTH];  // Translations
  logic [IDX_W-1:0] victim_reg;         // Round-robin prefetch slot

  // Entry writes; diagnose write wins over a prefetch in the same cycle
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      for (int i = 0; i < DEPTH; i++) begin
        entry_reg[i] <= '0;
      end
    end else if (diag_wr_i) begin
      entry_reg[diag_idx_i] <= diag_entry_i;
    end else if (pf_enable_i && pf_valid_i) begin
      entry_reg[victim_reg] <= pf_entry_i;
    end
  end

  // Victim pointer steps only on prefetch fills
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      victim_reg <= '0;
    end else if (!diag_wr_i && pf_enable_i && pf_valid_i) begin
      victim_reg <= victim_reg + IDX_W'(1);
    end
  end

  // Combinational read port
  assign rd_entry_o = entry_reg[rd_idx_i];
endmodule

/* File: logic/cdb_pkg.sv */
// Package for the CPU diagnose and configuration register bank
package cdb_pkg;
  // Diagnose register file shape
  localparam int DIAG_COUNT = 35;           // Registers in total
  localparam int PAGE_SIZE  = 32;           // Reach of a 5-bit register number
  localparam int NUM_W      = 5;            // Register number width
  localparam int LAB_DEPTH  = 4;            // Lookaside buffer entries
  localparam int LAB_IDX_W  = 2;            // Lookaside buffer index width
  localparam int TRANS_W    = 20;           // Page number width

  // Wishbone byte offsets
  localparam logic [7:0] OFS_PAGE      = 8'h00;  // Current page, read only
  localparam logic [7:0] OFS_PAGE0_CMD = 8'h04;  // Select first page
  localparam logic [7:0] OFS_PAGE1_CMD = 8'h08;  // Select second page
  localparam logic [7:0] OFS_NUMBER    = 8'h0c;  // Register number for moves
  localparam logic [7:0] OFS_DATA      = 8'h10;  // Move-to on write, move-from on read
  localparam logic [7:0] OFS_IC_DIAG   = 8'h14;  // Start icache diagnose op
  localparam logic [7:0] OFS_DC_DIAG   = 8'h18;  // Start dcache diagnose op
  localparam logic [7:0] OFS_LAB_CMD   = 8'h1c;  // Lookaside buffer read or write
  localparam logic [7:0] OFS_STATUS    = 8'h20;  // Busy flags

  // Field positions
  localparam int CFG_IDX        = 0;   // Config register number
  localparam int CFG_SAFE_BIT   = 0;   // dcache_safe_mode
  localparam int CFG_SOU_BIT    = 1;   // stall_on_use_enable
  localparam int CFG_SHINT_BIT  = 2;   // store_hint_enable
  localparam int CFG_ICACHE_BIT = 3;   // icache_enable
  localparam int CFG_INTCHK_BIT = 4;   // int_bus_opcode_check_enable
  localparam int CFG_LDCHK_BIT  = 5;   // ldst_bus_opcode_check_enable
  localparam int PREF_IDX       = 7;   // Holds lookaside_prefetch_enable
  localparam int PREF_BIT       = 0;
  localparam int TEST_IDX       = 11;  // Holds dcache_test_mode
  localparam int TEST_BIT       = 0;
  localparam int LAB_VPN_IDX    = 32;  // Virtual page staging register
  localparam int LAB_RPN_IDX    = 33;  // Real page staging register
  localparam int LAB_CMD_WR_BIT = 8;   // 1 = write entry, 0 = read entry
  localparam int DIAG_BIST_BIT  = 0;   // 1 = self-test, 0 = diagnose
  localparam int STAT_IC_BIT    = 0;   // Icache op running
  localparam int STAT_DC_BIT    = 1;   // Dcache op running

  // Reset values
  localparam logic [31:0] CFG_RESET   = 32'h0000_0008;  // Icache enabled
  localparam logic [31:0] OTHER_RESET = 32'h0000_0000;

  // Controls handed to the core
  typedef struct packed {
    logic dcache_safe_mode;
    logic stall_on_use_enable;
    logic store_hint_enable;
    logic icache_enable;
    logic dcache_test_mode;
    logic lookaside_prefetch_enable;
  } cdb_core_ctrl_s;

  // One lookaside buffer translation
  typedef struct packed {
    logic [TRANS_W-1:0] vpn;
    logic [TRANS_W-1:0] rpn;
  } cdb_lab_entry_s;
endpackage

/* File: sim/cdb_eng_model.sv */
// Behavioural cache diagnose engine answering start pulses
`timescale 1ns/10ps
module cdb_eng_model #(
  parameter int LAT = 3          // Cycles from start to done
) (
  input  wire logic clk_i,
  input  wire logic reset_i,
  input  wire logic start_i,
  output logic      done_o
);
  int cnt_reg;                   // Cycles left, zero when idle
  // one done pulse per started operation not cut short by a restart
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      cnt_reg <= 0;
      done_o  <= 1'b0;
    end else begin
      done_o <= (cnt_reg == 1);
      // Restart wins, as a real engine would abort and rerun
      if (start_i) begin
        cnt_reg <= LAT;
      end else if (cnt_reg != 0) begin
        cnt_reg <= cnt_reg - 1;
      end
    end
  end
endmodule

/* File: sim/cdb_sva.sv */
// Port checker for the diagnose and configuration bank
`timescale 1ns/10ps
module cdb_sva (
  input  wire logic               CLK_I,
  input  wire logic               RESET_I,
  input  wire logic               CYC_I,
  input  wire logic               STB_I,
  input  wire logic               ACK_O,
  input  cdb_pkg::cdb_core_ctrl_s CORE_CTRL_O,
  input  wire logic               INT_INSN_VALID_I,
  input  wire logic               INT_MINOR_UNDEF_I,
  input  wire logic               LDST_INSN_VALID_I,
  input  wire logic               LDST_MINOR_UNDEF_I,
  input  wire logic               LDST_INSN_IS_FP_I,
  input  wire logic               ILLEGAL_TRAP_O,
  input  wire logic               LOAD_MISS_I,
  input  wire logic               LOAD_MISS_DEFER_O,
  input  wire logic               ICACHE_DIAG_START_O,
  input  wire logic               DCACHE_DIAG_START_O
);
  // One domain, so clock and reset are given once
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (RESET_I);

  // Request answered in the next cycle
  a_ack_answer: assert property (CYC_I && STB_I && !ACK_O |=> ACK_O)
    else $error("bus request not answered next cycle");
  // Answer is a single-cycle pulse
  a_ack_pulse: assert property (ACK_O |=> !ACK_O)
    else $error("bus answer held too long");
  // controls move only with a write answer
  a_ctrl_by_write: assert property (!$stable(CORE_CTRL_O) |-> ACK_O)
    else $error("core control changed without a bus answer");
  // a trap always has an offending instruction
  a_trap_cause: assert property (ILLEGAL_TRAP_O |-> $past(INT_INSN_VALID_I && INT_MINOR_UNDEF_I)
    || $past(LDST_INSN_VALID_I && LDST_MINOR_UNDEF_I && !LDST_INSN_IS_FP_I))
    else $error("trap raised with no undefined opcode");
  a_fp_no_trap: assert property (LDST_INSN_IS_FP_I && !(INT_INSN_VALID_I && INT_MINOR_UNDEF_I)
    |=> !ILLEGAL_TRAP_O)
    else $error("floating point instruction trapped");
  // deferral follows load miss and enable only
  a_defer_load: assert property (##1 LOAD_MISS_DEFER_O ==
    ($past(LOAD_MISS_I) && $past(CORE_CTRL_O.stall_on_use_enable)))
    else $error("load miss deferral wrong");
  // icache start only with a bus answer, one cycle
  a_icache_start: assert property (ICACHE_DIAG_START_O |-> ACK_O ##1 !ICACHE_DIAG_START_O)
    else $error("icache start pulse out of place");
  // dcache start only with a bus answer, one cycle
  a_dcache_start: assert property (DCACHE_DIAG_START_O |-> ACK_O ##1 !DCACHE_DIAG_START_O)
    else $error("dcache start pulse out of place");
endmodule

/* File: sim/tb.sv */
// Self-checking bench for the diagnose and configuration bank
`timescale 1ns/10ps
module tb;
  import cdb_pkg::*;
  logic clk = 1'b0, rst = 1'b1;            // Clock and reset
  logic cyc = 1'b0, stb = 1'b0, we = 1'b0;  // Bus strobes
  logic [7:0] adr = 8'h00;                  // Bus address
  logic [31:0] wdat = 32'h0, rdat, q;       // Bus data
  logic ack, trap, defer, ics, dcs, bist, icd, dcd;
  logic ivv = 1'b0, iu = 1'b0, lv = 1'b0, lu = 1'b0, fpf = 1'b0, lm = 1'b0, pfv = 1'b0;
  logic [1:0] lidx = 2'h0;                  // Lookup index
  cdb_core_ctrl_s ctrl;                     // Controls seen
  cdb_lab_entry_s pfe = '0, lent, e;        // Lookaside entries
  logic [31:0] v [4];                       // Page one values
  logic [31:0] r0;                          // Model of config register
  logic [5:0] st;                           // Instruction stimulus
  int err_total = 0, checks_done = 0;

  always #50 clk = ~clk;

  cdb_bank dut_u (.CLK_I(clk), .RESET_I(rst), .CYC_I(cyc), .STB_I(stb), .WE_I(we), .ADR_I(adr),
    .SEL_I(4'hf), .DAT_I(wdat), .DAT_O(rdat), .ACK_O(ack), .CORE_CTRL_O(ctrl),
    .INT_INSN_VALID_I(ivv), .INT_MINOR_UNDEF_I(iu), .LDST_INSN_VALID_I(lv), .LDST_MINOR_UNDEF_I(lu),
    .LDST_INSN_IS_FP_I(fpf), .ILLEGAL_TRAP_O(trap), .LOAD_MISS_I(lm), .LOAD_MISS_DEFER_O(defer),
    .ICACHE_DIAG_START_O(ics), .DCACHE_DIAG_START_O(dcs), .CACHE_DIAG_BIST_O(bist),
    .ICACHE_DIAG_DONE_I(icd), .DCACHE_DIAG_DONE_I(dcd), .LAB_PF_VALID_I(pfv),
    .LAB_PF_ENTRY_I(pfe), .LAB_LOOKUP_IDX_I(lidx), .LAB_LOOKUP_ENTRY_O(lent));
  // Slow icache engine, prompt dcache engine
  cdb_eng_model #(.LAT(8)) ieng_u (.clk_i(clk), .reset_i(rst), .start_i(ics), .done_o(icd));
  cdb_eng_model #(.LAT(1)) deng_u (.clk_i(clk), .reset_i(rst), .start_i(dcs), .done_o(dcd));

  // Compare and count
  task automatic chk(input logic [63:0] s, input logic [63:0] x);
    checks_done++;
    if (s !== x) begin
      err_total++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, x);
    end
  endtask

  // Classic single cycle; waits for ack, watchdog bounds it
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    @(posedge clk);
    while (ack !== 1'b1) @(posedge clk);
    r = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask

  // Registered lookup, seen two edges after the index
  task automatic look(input logic [1:0] i, input cdb_lab_entry_s x);
    @(posedge clk);
    lidx <= i;
    repeat (2) @(posedge clk);
    chk(lent, x);
  endtask

  // Controls expected from config, prefetch and test registers
  function automatic cdb_core_ctrl_s exp_ctrl(input logic [31:0] c0, input logic p, input logic t);
    exp_ctrl.dcache_safe_mode = c0[CFG_SAFE_BIT];
    exp_ctrl.stall_on_use_enable = c0[CFG_SOU_BIT];
    exp_ctrl.store_hint_enable = c0[CFG_SHINT_BIT];
    exp_ctrl.icache_enable = c0[CFG_ICACHE_BIT];
    exp_ctrl.dcache_test_mode = t;
    exp_ctrl.lookaside_prefetch_enable = p;
  endfunction

  // Trap expected from enables and {ivv,iu,lv,lu,fpf,lm}
  function automatic logic exp_trap(input logic [31:0] c0, input logic [5:0] s);
    return (c0[CFG_INTCHK_BIT] & s[5] & s[4]) | (c0[CFG_LDCHK_BIT] & s[3] & s[2] & !s[1]);
  endfunction

  task automatic print_verdict;
    if (err_total == 0 && checks_done > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  // Watchdog, far beyond the few hundred cycles the tests need
  initial begin
    repeat (20000) @(posedge clk);
    err_total++;
    print_verdict();
  end

  initial begin
    void'($urandom(56));
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    wb(0, OFS_PAGE, 0, q);
    chk(q, 0);
    chk(ctrl, exp_ctrl(CFG_RESET, 0, 0));
    wb(0, OFS_DATA, 0, q);
    chk(q, CFG_RESET);
    // Second page: three real registers, the fourth absent
    wb(1, OFS_PAGE1_CMD, 0, q);
    wb(0, OFS_PAGE, 0, q);
    chk(q, 1);
    for (int i = 0; i < 4; i++) begin
      v[i] = $urandom;
      wb(1, OFS_NUMBER, i, q);
      wb(1, OFS_DATA, v[i], q);
    end
    for (int i = 0; i < 4; i++) begin
      wb(1, OFS_NUMBER, i, q);
      wb(0, OFS_DATA, 0, q);
      chk(q, (i < 3) ? v[i] : 32'h0);
    end
    // Lookaside write from staging, then read back into it
    e = {v[0][TRANS_W-1:0], v[1][TRANS_W-1:0]};
    wb(1, OFS_LAB_CMD, 32'h0000_0102, q);
    look(2, e);
    for (int i = 0; i < 2; i++) begin
      wb(1, OFS_NUMBER, i, q);
      wb(1, OFS_DATA, 0, q);
    end
    wb(1, OFS_LAB_CMD, 32'h0000_0002, q);
    for (int i = 0; i < 2; i++) begin
      wb(1, OFS_NUMBER, i, q);
      wb(0, OFS_DATA, 0, q);
      chk(q[TRANS_W-1:0], v[i][TRANS_W-1:0]);
    end
    // Back to the first page; unmapped place reads zero
    wb(1, OFS_PAGE0_CMD, 0, q);
    wb(1, 8'h40, 32'hffff_ffff, q);
    wb(0, 8'h40, 0, q);
    chk(q, 0);
    // Prefetch fill ignored while disabled, taken once enabled
    @(posedge clk);
    pfe <= {20'($urandom), 20'($urandom)};
    pfv <= 1'b1;
    @(posedge clk);
    pfv <= 1'b0;
    look(0, '0);
    wb(1, OFS_NUMBER, PREF_IDX, q);
    wb(1, OFS_DATA, 1, q);
    wb(1, OFS_NUMBER, TEST_IDX, q);
    wb(1, OFS_DATA, 1, q);
    chk(ctrl, exp_ctrl(CFG_RESET, 1, 1));
    wb(1, OFS_DATA, 0, q);
    @(posedge clk);
    pfv <= 1'b1;
    @(posedge clk);
    pfv <= 1'b0;
    look(0, pfe);
    // Cache diagnose starts: mode level and busy flags
    wb(1, OFS_IC_DIAG, 1, q);
    chk(bist, 1);
    wb(0, OFS_STATUS, 0, q);
    chk(q[STAT_IC_BIT], 1);
    wb(1, OFS_DC_DIAG, 0, q);
    chk(bist, 0);
    repeat (20) @(posedge clk);
    wb(0, OFS_STATUS, 0, q);
    chk(q[1:0], 2'h0);
    // Random config with random instruction traffic
    wb(1, OFS_NUMBER, CFG_IDX, q);
    for (int n = 0; n < 32; n++) begin
      r0 = (n == 0) ? 32'h38 : (($urandom & 32'h3f) | 32'h08);
      st = (n == 0) ? 6'h0e : 6'($urandom);
      wb(1, OFS_DATA, r0, q);
      chk(ctrl, exp_ctrl(r0, 1, 0));
      @(posedge clk);
      {ivv, iu, lv, lu, fpf, lm} <= st;
      @(posedge clk);
      {ivv, iu, lv, lu, fpf, lm} <= 6'h00;
      @(posedge clk);
      chk(trap, exp_trap(r0, st));
      chk(defer, r0[CFG_SOU_BIT] & st[0]);
    end
    print_verdict();
  end
endmodule

bind cdb_bank cdb_sva chk_u (.CLK_I(CLK_I), .RESET_I(RESET_I), .CYC_I(CYC_I), .STB_I(STB_I),
  .ACK_O(ACK_O), .CORE_CTRL_O(CORE_CTRL_O), .INT_INSN_VALID_I(INT_INSN_VALID_I),
  .INT_MINOR_UNDEF_I(INT_MINOR_UNDEF_I), .LDST_INSN_VALID_I(LDST_INSN_VALID_I),
  .LDST_MINOR_UNDEF_I(LDST_MINOR_UNDEF_I), .LDST_INSN_IS_FP_I(LDST_INSN_IS_FP_I),
  .ILLEGAL_TRAP_O(ILLEGAL_TRAP_O), .LOAD_MISS_I(LOAD_MISS_I), .LOAD_MISS_DEFER_O(LOAD_MISS_DEFER_O),
  .ICACHE_DIAG_START_O(ICACHE_DIAG_START_O), .DCACHE_DIAG_START_O(DCACHE_DIAG_START_O));
